// ===== rtl/e1rsm_pkg.sv
// Constants for the E1 receive status monitor.
// Assumes a 40 MHz mclk and line-side strobes synchronous to it.
package e1rsm_pkg;
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned T_HALF_SEC_MS = 500;
    localparam int unsigned T_ALIGN_MS = 400;
    localparam int unsigned T_MS_US = 1000;
    localparam int unsigned T_KEEP_ALIVE_MS = 100;
    localparam int unsigned T_FRAME_LOSS_MS = 100;
    localparam int unsigned T_FRAME_GAIN_MS = 10;
    localparam int unsigned T_PHASE_US = 250;
    localparam int unsigned CYC_HALF_SEC = CLK_KHZ * T_HALF_SEC_MS;
    localparam int unsigned CYC_ALIGN = CLK_KHZ * T_ALIGN_MS;
    localparam int unsigned CYC_MS = (CLK_KHZ * T_MS_US) / 1000;
    localparam int unsigned CYC_KEEP_ALIVE = CLK_KHZ * T_KEEP_ALIVE_MS;
    localparam int unsigned CYC_FRAME_LOSS = CLK_KHZ * T_FRAME_LOSS_MS;
    localparam int unsigned CYC_FRAME_GAIN = CLK_KHZ * T_FRAME_GAIN_MS;
    localparam int unsigned CYC_PHASE = (CLK_KHZ * T_PHASE_US) / 1000;
    localparam logic [7:0] LOS_WINDOW = 8'hC0;
    localparam logic [7:0] LOS_MIN_ONES = 8'h18;
    localparam logic [9:0] AUX_WINDOW = 10'h200;
    localparam logic [1:0] AUX_MAX_ERR = 2'h1;
    localparam logic [9:0] AIS_WINDOW = 10'h200;
    localparam logic [1:0] AIS_MAX_ZEROS = 2'h2;
    localparam logic [4:0] ADDR_ALARM_ONE = 5'h11;
    localparam logic [4:0] ADDR_TIMER = 5'h12;
    localparam logic [4:0] ADDR_PHASE_HIGH = 5'h13;
    localparam logic [4:0] ADDR_PHASE_LOW = 5'h14;
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

// ===== rtl/e1rsm_status.sv
// Receive alarm, timer and slip status words with a read-only host port.
// Assumes all inputs synchronous to mclk; strobes are one-cycle pulses.
module e1rsm_status #(
    parameter int unsigned HALF_SEC_CYC = e1rsm_pkg::CYC_HALF_SEC,
    parameter int unsigned ALIGN_CYC = e1rsm_pkg::CYC_ALIGN,
    parameter int unsigned MS_CYC = e1rsm_pkg::CYC_MS,
    parameter int unsigned KEEP_ALIVE_CYC = e1rsm_pkg::CYC_KEEP_ALIVE,
    parameter int unsigned FRAME_LOSS_CYC = e1rsm_pkg::CYC_FRAME_LOSS,
    parameter int unsigned FRAME_GAIN_CYC = e1rsm_pkg::CYC_FRAME_GAIN,
    parameter int unsigned PHASE_CYC = e1rsm_pkg::CYC_PHASE
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Receive bit stream
    input wire logic line_bit_valid,
    input wire logic line_bit,
    // Framer events
    input wire logic frame_strobe,
    input wire logic ch16_all_ones,
    input wire logic nfas_strobe,
    input wire logic a_bit,
    input wire logic fas_strobe,
    input wire logic fas_error,
    input wire logic mframe_strobe,
    input wire logic crc_continuous_error,
    input wire logic crc_mf_aligned,
    input wire logic crc_sync_pulse,
    input wire logic frame_sync_lost,
    input wire logic nonnormal_frame,
    input wire logic alarm_criterion_select,
    // Elastic buffer
    input wire logic slip_event,
    input wire logic slip_repeat,
    input wire logic delay_under_frame,
    input wire logic [4:0] write_ts_phase,
    input wire logic [2:0] write_bit_phase,
    // Host read port
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    output logic [7:0] host_rdata
);
    import e1rsm_pkg::*;

    logic signal_absent;
    logic [7:0] zero_run;
    logic los_win_active;
    logic [7:0] los_win_cnt;
    logic [7:0] los_ones;
    logic ch16_all_ones_flag;
    logic all_ones_alarm_flag;
    logic [9:0] ais_bits;
    logic [1:0] ais_zeros;
    logic ais_prev_ok;
    logic far_end_alarm_flag;
    logic far_alarm_crc_error_flag;
    logic [31:0] half_cnt;
    logic half_second_toggle;
    logic one_second_toggle;
    logic [31:0] align_cnt;
    logic align_timeout_toggle;
    logic [31:0] ms_cnt;
    logic crc_align_ms_toggle;
    logic [31:0] ka_cnt;
    logic keep_alive_flag;
    logic [31:0] loss_cnt;
    logic frame_loss_timer_flag;
    logic [31:0] gain_cnt;
    logic frame_gain_timer_flag;
    logic slip_toggle;
    logic slip_direction;
    logic buffer_delay_msb;
    logic [9:0] aux_bits;
    logic [1:0] aux_errs;
    logic aux_prev;
    logic alternating_pattern_flag;
    logic fas_err_last;
    logic consecutive_fas_error_flag;
    logic [31:0] phase_cnt;
    logic [4:0] phase_timeslot_count;
    logic [2:0] phase_bit_count;

    // Loss of signal
    wire zero_bit = line_bit_valid && !line_bit;
    wire los_set = zero_bit && (zero_run == LOS_WINDOW - 8'h01);
    wire los_start = signal_absent && !los_win_active && line_bit_valid && line_bit;
    wire los_win_end = los_win_active && line_bit_valid && (los_win_cnt == LOS_WINDOW - 8'h01);
    wire [7:0] los_ones_total = los_ones + {7'h00, line_bit};
    wire los_clear = los_win_end && (los_ones_total >= LOS_MIN_ONES);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zero_run <= 8'h00;
            signal_absent <= 1'b0;
            los_win_active <= 1'b0;
            los_win_cnt <= 8'h00;
            los_ones <= 8'h00;
        end else begin
            if (line_bit_valid) begin
                zero_run <= (line_bit || los_set) ? 8'h00 : zero_run + 8'h01;
            end
            if (los_set) begin
                signal_absent <= 1'b1;
            end else if (los_clear) begin
                signal_absent <= 1'b0;
            end
            if (los_start) begin
                los_win_active <= 1'b1;
                los_win_cnt <= 8'h01;
                los_ones <= 8'h01;
            end else if (los_win_end || !signal_absent) begin
                los_win_active <= 1'b0;
            end else if (los_win_active && line_bit_valid) begin
                los_win_cnt <= los_win_cnt + 8'h01;
                los_ones <= los_ones_total;
            end
        end
    end

    // All-ones detection over 512-bit blocks; criterion 1 needs two good blocks in a row
    wire ais_end = line_bit_valid && (ais_bits == AIS_WINDOW - 10'h001);
    wire ais_block_ok = (ais_zeros + {1'b0, zero_bit}) <= AIS_MAX_ZEROS && !(zero_bit && ais_zeros == 2'h3);
    wire ais_valid = ais_block_ok && (!alarm_criterion_select || ais_prev_ok);

    // Alternating pattern: count breaks of alternation in each 512-bit block
    wire aux_err = line_bit_valid && (line_bit == aux_prev);
    wire aux_end = line_bit_valid && (aux_bits == AUX_WINDOW - 10'h001);
    wire aux_ok = (aux_errs + {1'b0, aux_err}) <= AUX_MAX_ERR && !(aux_err && aux_errs == 2'h3);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ais_bits <= 10'h000;
            ais_zeros <= 2'h0;
            ais_prev_ok <= 1'b0;
            all_ones_alarm_flag <= 1'b0;
            aux_bits <= 10'h000;
            aux_errs <= 2'h0;
            aux_prev <= 1'b0;
            alternating_pattern_flag <= 1'b0;
        end else begin
            if (line_bit_valid) begin
                ais_bits <= ais_end ? 10'h000 : ais_bits + 10'h001;
                aux_bits <= aux_end ? 10'h000 : aux_bits + 10'h001;
                aux_prev <= line_bit;
            end
            if (ais_end) begin
                ais_zeros <= 2'h0;
                ais_prev_ok <= ais_block_ok;
                all_ones_alarm_flag <= ais_valid;
            end else if (zero_bit && ais_zeros != 2'h3) begin
                ais_zeros <= ais_zeros + 2'h1;
            end
            if (aux_end) begin
                aux_errs <= 2'h0;
                alternating_pattern_flag <= aux_ok;
            end else if (aux_err && aux_errs != 2'h3) begin
                aux_errs <= aux_errs + 2'h1;
            end
        end
    end

    // Frame-rate alarms and slip indication
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ch16_all_ones_flag <= 1'b0;
            far_end_alarm_flag <= 1'b0;
            far_alarm_crc_error_flag <= 1'b0;
            fas_err_last <= 1'b0;
            consecutive_fas_error_flag <= 1'b0;
            slip_toggle <= 1'b0;
            slip_direction <= 1'b0;
        end else begin
            if (frame_strobe) begin
                ch16_all_ones_flag <= ch16_all_ones;
            end
            if (nfas_strobe) begin
                far_end_alarm_flag <= a_bit;
            end
            if (mframe_strobe) begin
                far_alarm_crc_error_flag <= far_end_alarm_flag && crc_continuous_error;
            end
            if (fas_strobe) begin
                fas_err_last <= fas_error;
                consecutive_fas_error_flag <= fas_error && fas_err_last;
            end
            if (slip_event) begin
                slip_toggle <= !slip_toggle;
                slip_direction <= slip_repeat;
            end
        end
    end

    // Free-running and persistence timers
    wire half_end = (half_cnt == 32'(HALF_SEC_CYC - 1));
    wire align_end = !crc_mf_aligned && (align_cnt == 32'(ALIGN_CYC - 1));
    wire ms_sync = crc_mf_aligned && crc_sync_pulse;
    wire ms_end = ms_sync || (ms_cnt == 32'(MS_CYC - 1));
    wire ka_done = (ka_cnt == 32'(KEEP_ALIVE_CYC - 1));
    wire loss_done = (loss_cnt == 32'(FRAME_LOSS_CYC - 1));
    wire gain_done = (gain_cnt == 32'(FRAME_GAIN_CYC - 1));
    wire gain_run = !frame_sync_lost && !nonnormal_frame;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            half_cnt <= 32'h0000_0000;
            half_second_toggle <= 1'b0;
            one_second_toggle <= 1'b0;
            align_cnt <= 32'h0000_0000;
            align_timeout_toggle <= 1'b0;
            ms_cnt <= 32'h0000_0000;
            crc_align_ms_toggle <= 1'b0;
        end else begin
            half_cnt <= half_end ? 32'h0000_0000 : half_cnt + 32'h0000_0001;
            if (half_end) begin
                half_second_toggle <= !half_second_toggle;
                one_second_toggle <= one_second_toggle ^ half_second_toggle;
            end
            align_cnt <= (align_end || crc_mf_aligned) ? 32'h0000_0000 : align_cnt + 32'h0000_0001;
            if (align_end) begin
                align_timeout_toggle <= !align_timeout_toggle;
            end
            ms_cnt <= ms_end ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
            if (ms_end) begin
                crc_align_ms_toggle <= !crc_align_ms_toggle;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ka_cnt <= 32'h0000_0000;
            keep_alive_flag <= 1'b0;
            loss_cnt <= 32'h0000_0000;
            frame_loss_timer_flag <= 1'b0;
            gain_cnt <= 32'h0000_0000;
            frame_gain_timer_flag <= 1'b0;
        end else begin
            ka_cnt <= (!all_ones_alarm_flag || ka_done) ? 32'h0000_0000 : ka_cnt + 32'h0000_0001;
            if (!all_ones_alarm_flag) begin
                keep_alive_flag <= 1'b0;
            end else if (ka_done) begin
                keep_alive_flag <= 1'b1;
            end
            loss_cnt <= (!frame_sync_lost || loss_done) ? 32'h0000_0000 : loss_cnt + 32'h0000_0001;
            if (gain_done && gain_run) begin
                frame_loss_timer_flag <= 1'b0;
            end else if (loss_done && frame_sync_lost) begin
                frame_loss_timer_flag <= 1'b1;
            end
            gain_cnt <= (!gain_run || gain_done) ? 32'h0000_0000 : gain_cnt + 32'h0000_0001;
            if (!gain_run) begin
                frame_gain_timer_flag <= 1'b0;
            end else if (gain_done) begin
                frame_gain_timer_flag <= 1'b1;
            end
        end
    end

    // Buffer phase snapshot
    wire phase_end = (phase_cnt == 32'(PHASE_CYC - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_cnt <= 32'h0000_0000;
            phase_timeslot_count <= 5'h00;
            phase_bit_count <= 3'h0;
            buffer_delay_msb <= 1'b0;
        end else begin
            phase_cnt <= phase_end ? 32'h0000_0000 : phase_cnt + 32'h0000_0001;
            buffer_delay_msb <= delay_under_frame;
            if (phase_end) begin
                phase_timeslot_count <= write_ts_phase;
                phase_bit_count <= write_bit_phase;
            end
        end
    end

    // Status word assembly and read-only host decode
    wire [7:0] alarm_status_one = {3'h0, signal_absent, ch16_all_ones_flag, all_ones_alarm_flag,
                                   far_end_alarm_flag, far_alarm_crc_error_flag};
    wire [7:0] timer_status_word = {half_second_toggle, one_second_toggle, align_timeout_toggle, 1'b0,
                                    crc_align_ms_toggle, keep_alive_flag, frame_loss_timer_flag,
                                    frame_gain_timer_flag};
    wire [7:0] slip_phase_high = {slip_toggle, slip_direction, buffer_delay_msb, alternating_pattern_flag,
                                  consecutive_fas_error_flag, 3'h0};
    wire [7:0] slip_phase_low = {phase_timeslot_count, phase_bit_count};
    wire [7:0] next_rdata = (host_addr == ADDR_ALARM_ONE) ? alarm_status_one :
                            (host_addr == ADDR_TIMER) ? timer_status_word :
                            (host_addr == ADDR_PHASE_HIGH) ? slip_phase_high :
                            (host_addr == ADDR_PHASE_LOW) ? slip_phase_low : STATUS_RESET;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            host_rdata <= STATUS_RESET;
        end else if (host_cs && host_rd) begin
            host_rdata <= next_rdata;
        end
    end
endmodule

// ===== dv/e1rsm_status_props.sv
// Checker for the status monitor read port and event flags.
// Sees only the top module ports; bound from the bench.
module e1rsm_status_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Framer and buffer events
    input wire logic frame_strobe,
    input wire logic ch16_all_ones,
    input wire logic nfas_strobe,
    input wire logic a_bit,
    input wire logic fas_strobe,
    input wire logic fas_error,
    input wire logic slip_event,
    input wire logic slip_repeat,
    input wire logic delay_under_frame,
    // Host read port
    input wire logic host_cs,
    input wire logic host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import e1rsm_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire rd_take = host_cs && host_rd;
    wire rd_alarm = rd_take && host_addr == ADDR_ALARM_ONE;
    wire rd_phase = rd_take && host_addr == ADDR_PHASE_HIGH;
    property p_read_hold; !rd_take |=> $stable(host_rdata); endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");
    property p_unmapped; rd_take && (host_addr < ADDR_ALARM_ONE || host_addr > ADDR_PHASE_LOW) |=> host_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");
    property p_alarm_pad; rd_alarm |=> host_rdata[7:5] == 3'h0; endproperty
    a_alarm_pad: assert property (p_alarm_pad) else $error("alarm word spare bits set");
    property p_phase_pad; rd_phase |=> host_rdata[2:0] == 3'h0; endproperty
    a_phase_pad: assert property (p_phase_pad) else $error("phase word spare bits set");
    property p_far_end; (nfas_strobe && a_bit) ##1 (rd_alarm && !nfas_strobe) |=> host_rdata[1]; endproperty
    a_far_end: assert property (p_far_end) else $error("far-end alarm not set");
    property p_ch16; (frame_strobe && !ch16_all_ones) ##1 (rd_alarm && !frame_strobe) |=> !host_rdata[3]; endproperty
    a_ch16: assert property (p_ch16) else $error("channel 16 flag not cleared");
    property p_fas_ok; (fas_strobe && !fas_error) ##1 (rd_phase && !fas_strobe) |=> !host_rdata[3]; endproperty
    a_fas_ok: assert property (p_fas_ok) else $error("fas error flag kept after good fas");
    property p_slip_dir; (slip_event && slip_repeat) ##1 (rd_phase && !slip_event) |=> host_rdata[6]; endproperty
    a_slip_dir: assert property (p_slip_dir) else $error("slip direction not repeat");
    property p_delay_msb; rd_phase && $stable(delay_under_frame) |=> host_rdata[5] == $past(delay_under_frame);
    endproperty
    a_delay_msb: assert property (p_delay_msb) else $error("delay msb wrong");
endmodule

// ===== dv/e1rsm_line_model.sv
// Far-end line model: one received bit every second mclk cycle.
// Assumes the bench calls send from a falling edge.
module e1rsm_line_model (
    // Clock
    input wire logic mclk,
    // Line side
    output logic line_bit_valid,
    output logic line_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned sent = 0;
    initial begin
        line_bit_valid = 1'b0;
        line_bit = 1'b0;
    end
    // Modes: zeros, ones, alternating, one in eight
    task automatic send(input int n, input int mode);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            line_bit_valid = 1'b1;
            case (mode)
                0: line_bit = 1'b0;
                1: line_bit = 1'b1;
                2: line_bit = sent[0];
                default: line_bit = (sent % 8 == 0);
            endcase
            sent++;
            @(negedge mclk);
            line_bit_valid = 1'b0;
            // Stale data is not held
            line_bit = ~line_bit;
        end
    endtask
endmodule

// ===== dv/e1rsm_status_bench.sv
// Self-checking bench for the receive status monitor.
// Shortened timer counts; line bits come from the line model.
bind e1rsm_status e1rsm_status_props e1rsm_status_props_i (.mclk(mclk), .resetn(resetn),
    .frame_strobe(frame_strobe), .ch16_all_ones(ch16_all_ones), .nfas_strobe(nfas_strobe), .a_bit(a_bit),
    .fas_strobe(fas_strobe), .fas_error(fas_error), .slip_event(slip_event), .slip_repeat(slip_repeat),
    .delay_under_frame(delay_under_frame), .host_cs(host_cs), .host_rd(host_rd), .host_addr(host_addr),
    .host_rdata(host_rdata));
module e1rsm_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 40;
    localparam int ALIGN = 30;
    localparam int MSC = 8;
    localparam int KEEP = 20;
    localparam int LOSS = 20;
    logic mclk, resetn, line_bit_valid, line_bit, frame_strobe, ch16_all_ones, nfas_strobe, a_bit, fas_strobe;
    logic fas_error, mframe_strobe, crc_continuous_error, crc_mf_aligned, crc_sync_pulse, frame_sync_lost;
    logic nonnormal_frame, alarm_criterion_select, slip_event, slip_repeat, delay_under_frame, host_cs, host_rd;
    logic [4:0] write_ts_phase, host_addr;
    logic [2:0] write_bit_phase;
    logic [7:0] host_rdata;
    int error_cnt = 0;
    int comparisons = 0;
    e1rsm_status #(.HALF_SEC_CYC(HALF), .ALIGN_CYC(ALIGN), .MS_CYC(MSC), .KEEP_ALIVE_CYC(KEEP),
        .FRAME_LOSS_CYC(LOSS), .FRAME_GAIN_CYC(6), .PHASE_CYC(10)) e1rsm_status_i (.mclk(mclk), .resetn(resetn),
        .line_bit_valid(line_bit_valid), .line_bit(line_bit), .frame_strobe(frame_strobe),
        .ch16_all_ones(ch16_all_ones), .nfas_strobe(nfas_strobe), .a_bit(a_bit), .fas_strobe(fas_strobe),
        .fas_error(fas_error), .mframe_strobe(mframe_strobe), .crc_continuous_error(crc_continuous_error),
        .crc_mf_aligned(crc_mf_aligned), .crc_sync_pulse(crc_sync_pulse), .frame_sync_lost(frame_sync_lost),
        .nonnormal_frame(nonnormal_frame), .alarm_criterion_select(alarm_criterion_select),
        .slip_event(slip_event), .slip_repeat(slip_repeat), .delay_under_frame(delay_under_frame),
        .write_ts_phase(write_ts_phase), .write_bit_phase(write_bit_phase), .host_cs(host_cs),
        .host_rd(host_rd), .host_addr(host_addr), .host_rdata(host_rdata));
    e1rsm_line_model e1rsm_line_model_i (.mclk(mclk), .line_bit_valid(line_bit_valid), .line_bit(line_bit));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        host_cs = 1'b1;
        host_rd = 1'b1;
        host_addr = a;
        @(negedge mclk);
        host_cs = 1'b0;
        host_rd = 1'b0;
        @(negedge mclk);
        chk($sformatf("word %h", a), host_rdata & m, e);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    task automatic to_block(input int mode, input int extra);
        e1rsm_line_model_i.send(512 - e1rsm_line_model_i.sent % 512 + extra, mode);
    endtask
    // Back-to-back reads of the timer word over 240 cycles
    task automatic tmr(input int e7, input int e5);
        logic [7:0] p;
        int c7, c6, c5, c3, odd;
        {c7, c6, c5, c3, odd} = '0;
        host_cs = 1'b1;
        host_rd = 1'b1;
        host_addr = 5'h12;
        repeat (2) @(negedge mclk);
        p = host_rdata;
        repeat (240) begin
            @(negedge mclk);
            c7 += int'(host_rdata[7] !== p[7]);
            c6 += int'(host_rdata[6] !== p[6]);
            c5 += int'(host_rdata[5] !== p[5]);
            c3 += int'(host_rdata[3] !== p[3]);
            odd += int'(host_rdata[6] !== p[6] && host_rdata[7] === p[7]);
            p = host_rdata;
        end
        host_cs = 1'b0;
        host_rd = 1'b0;
        chk("half toggles", 8'(c7), 8'(e7));
        chk("one toggles", 8'(c6), 8'(e7 / 2));
        chk("unaligned toggles", 8'(odd), 8'h00);
        chk("align toggles", 8'(c5), 8'(e5));
        chk("ms toggles", 8'(c3), 8'(240 / MSC));
    endtask
    // Sync pulse while aligned toggles and restarts the millisecond bit
    task automatic sync_chk();
        logic [7:0] p;
        @(negedge mclk);
        host_cs = 1'b1;
        host_rd = 1'b1;
        host_addr = 5'h12;
        crc_sync_pulse = 1'b1;
        @(negedge mclk);
        crc_sync_pulse = 1'b0;
        p = host_rdata;
        @(negedge mclk);
        chk("sync toggle", host_rdata & 8'h08, ~p & 8'h08);
        repeat (MSC - 1) @(negedge mclk);
        chk("sync hold", host_rdata & 8'h08, ~p & 8'h08);
        @(negedge mclk);
        chk("sync restart", host_rdata & 8'h08, p & 8'h08);
        host_cs = 1'b0;
        host_rd = 1'b0;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #1ms;
        error_cnt++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        {frame_strobe, ch16_all_ones, nfas_strobe, a_bit, fas_strobe, fas_error, mframe_strobe,
            crc_continuous_error, crc_mf_aligned, crc_sync_pulse, frame_sync_lost, nonnormal_frame,
            alarm_criterion_select, slip_event, slip_repeat, delay_under_frame, host_cs, host_rd,
            write_ts_phase, host_addr, write_bit_phase} = '0;
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        rc(5'h10, 8'hFF, 8'h00);
        rc(5'h11, 8'hFF, 8'h00);
        rc(5'h13, 8'hFF, 8'h00);
        rc(5'h1F, 8'hFF, 8'h00);
        e1rsm_line_model_i.send(191, 0);
        rc(5'h11, 8'h10, 8'h00);
        e1rsm_line_model_i.send(1, 0);
        rc(5'h11, 8'h10, 8'h10);
        e1rsm_line_model_i.send(191, 3);
        rc(5'h11, 8'h10, 8'h10);
        e1rsm_line_model_i.send(1, 3);
        rc(5'h11, 8'h10, 8'h00);
        to_block(1, 512);
        rc(5'h11, 8'h04, 8'h04);
        rc(5'h12, 8'h04, 8'h00);
        repeat (KEEP) @(negedge mclk);
        rc(5'h12, 8'h04, 8'h04);
        to_block(2, 512);
        rc(5'h13, 8'h10, 8'h10);
        rc(5'h11, 8'h04, 8'h00);
        rc(5'h12, 8'h04, 8'h00);
        alarm_criterion_select = 1'b1;
        to_block(1, 0);
        rc(5'h11, 8'h04, 8'h00);
        e1rsm_line_model_i.send(512, 1);
        rc(5'h11, 8'h04, 8'h04);
        rc(5'h13, 8'h10, 8'h00);
        a_bit = 1'b1;
        pulse(nfas_strobe);
        rc(5'h11, 8'h02, 8'h02);
        crc_continuous_error = 1'b1;
        pulse(mframe_strobe);
        rc(5'h11, 8'h01, 8'h01);
        a_bit = 1'b0;
        pulse(nfas_strobe);
        rc(5'h11, 8'h02, 8'h00);
        pulse(mframe_strobe);
        rc(5'h11, 8'h01, 8'h00);
        ch16_all_ones = 1'b1;
        pulse(frame_strobe);
        rc(5'h11, 8'h08, 8'h08);
        ch16_all_ones = 1'b0;
        pulse(frame_strobe);
        rc(5'h11, 8'h08, 8'h00);
        fas_error = 1'b1;
        pulse(fas_strobe);
        rc(5'h13, 8'h08, 8'h00);
        pulse(fas_strobe);
        rc(5'h13, 8'h08, 8'h08);
        fas_error = 1'b0;
        pulse(fas_strobe);
        rc(5'h13, 8'h08, 8'h00);
        slip_repeat = 1'b1;
        pulse(slip_event);
        rc(5'h13, 8'hC0, 8'hC0);
        slip_repeat = 1'b0;
        pulse(slip_event);
        rc(5'h13, 8'hC0, 8'h00);
        delay_under_frame = 1'b1;
        @(negedge mclk);
        rc(5'h13, 8'h20, 8'h20);
        write_ts_phase = 5'h15;
        write_bit_phase = 3'h6;
        repeat (12) @(negedge mclk);
        rc(5'h14, 8'hFF, 8'hAE);
        rc(5'h14, 8'hFF, 8'hAE);
        frame_sync_lost = 1'b1;
        repeat (LOSS + 4) @(negedge mclk);
        rc(5'h12, 8'h03, 8'h02);
        frame_sync_lost = 1'b0;
        repeat (8) @(negedge mclk);
        rc(5'h12, 8'h03, 8'h01);
        nonnormal_frame = 1'b1;
        @(negedge mclk);
        rc(5'h12, 8'h01, 8'h00);
        tmr(240 / HALF, 240 / ALIGN);
        crc_mf_aligned = 1'b1;
        tmr(240 / HALF, 0);
        sync_chk();
        wrap_up();
    end
endmodule
